/* File: design/i2ct_addr_cmp.sv */
/*
  Masked comparison of a received address against one target address.
  Assumes direction in bit 0 and address in bits 10:1 of each operand.
*/
`timescale 1ns/1ns
module i2ct_addr_cmp (
  input  wire logic [10:0] rx_addr,
  input  wire logic [10:0] ref_addr,
  input  wire logic [10:0] mask,
  input  wire logic        long_address_select,
  output logic             hit
);

  logic [10:0] care;

  // A short address only occupies bits 7:0, so upper mask bits are ignored.
  always_comb begin
    care = long_address_select ? mask : {3'b000, mask[7:0]};
    hit  = ((rx_addr ^ ref_addr) & care) == 11'h000;
  end

endmodule // i2ct_addr_cmp

/* File: design/i2ct_cfg.svh */
/*
  Offsets, field positions, reset values and limits of the target status block.
  Assumes byte addresses on an 8-bit register port with 32-bit words.
*/
`ifndef I2CT_CFG_SVH
`define I2CT_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define I2CT_OFF_STATUS   8'h00
`define I2CT_OFF_STATE    8'h04
`define I2CT_OFF_TXCNT    8'h08
`define I2CT_OFF_RXCNT    8'h0c
`define I2CT_OFF_IRQ_ENB  8'h10
`define I2CT_OFF_IRQ_RAW  8'h14
`define I2CT_OFF_IRQ_END  8'h18
`define I2CT_OFF_IRQ_CLR  8'h1c
`define I2CT_OFF_RXTRG    8'h20
`define I2CT_OFF_TXTRG    8'h24
`define I2CT_OFF_FLUSH    8'h28
`define I2CT_OFF_ADDRB    8'h2c
`define I2CT_OFF_MASKB    8'h30
`define I2CT_OFF_PERIPHERAL_IDENTITY    8'h34

// ----------------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------------
`define I2CT_ST_DONE      0
`define I2CT_ST_IDLE      1
`define I2CT_ST_WAIT      2
`define I2CT_ST_TXSTALL   3
`define I2CT_ST_RXSTALL   4
`define I2CT_ST_HIT       5
`define I2CT_ST_REFUSED   6
`define I2CT_ST_FIRST     7
`define I2CT_ST_RX_HAS_DATA  8
`define I2CT_ST_RX_AT_CAPACITY    9
`define I2CT_ST_RXTRIG    11
`define I2CT_ST_TX_DRAINED   12
`define I2CT_ST_TX_HAS_ROOM   13
`define I2CT_ST_TXLOW     15
`define I2CT_ST_BUSY      28
`define I2CT_ST_SDA       30
`define I2CT_ST_SCL       31
`define I2CT_ADDRB_EN     15

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define I2CT_STATUS_RST   32'h0000_0002
`define I2CT_TRG_RST      5'h08
`define I2CT_MASKB_RST    11'h7fe
`define I2CT_MASKB_ONES   21'h1f_ffff
`define I2CT_CNT_MAX      11'h7fe
`define I2CT_FIFO_FULL    5'h10
// Identity value is arbitrary.
`define I2CT_PERIPHERAL_IDENTITY        32'h5a5a_0001

`endif

/* File: design/i2ct_pkg.sv */
/*
  Types shared by the target status block.
  Assumes nothing of its surroundings.
*/
package i2ct_pkg;

  // --------------------------------------------------------------------------
  // Transaction phase
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ACTIVE,
    PH_HELD
  } i2ct_phase_type;

endpackage

/* File: design/i2ct_status.sv */
/*
  Status, word counting, interrupt, FIFO threshold and second address logic
  of an I2C target controller, with its register port.
  Assumes the bit shifter and FIFOs sit beside it on ref_clk and report events
  as one-cycle pulses; scl_pin and sda_pin come straight from the bus.
*/
// Our own choices: the placing of the registers and the strobed register port.
// Operation
// - Set done flag when a transaction ends by stop or repeated start.
// - Idle bit reads 1 when idle, 0 when busy; resets to 1.
// - Waiting bit set after a repeated start ends a transaction, until an address match or a stop.
// - Bit 3 shows stall for empty transmit FIFO.
// - Bit 4 shows stall for full receive FIFO.
// - Bit 5 on address match; bit 7 until first received byte follows.
// - Bit 6 set when a data word got a negative acknowledge.
// - Receive FIFO not empty, full, and at or above trigger bits.
// - Transmit FIFO empty, not full, and below trigger bits.
// - Test view shows state, step and both FIFO levels.
// - Count sent data words, 11 bits, holding at 0x7fe.
// - Count received data words, 11 bits, holding at 0x7fe.
// - Interrupt sources 7:0 latch on rising edges of status 7:0.
// - Sources 15:8 are start, stop, underrun, overrun, transmit low, receive trigger, empty, full.
// - Enables gate interrupts; raw and enabled views readable; enables reset 0.
// - Writing 1 to clear register clears that pending bit.
// - Receive trigger level, 5 bits, resets to 0x08.
// - Transmit trigger level, 5 bits, resets to 0x08.
// - Flush bit 0 empties receive FIFO, bit 1 transmit FIFO.
// - Second address matches where its mask bits are 1.
// - Second address used only when enabled; follows primary length mode.
// - Second address layout; mask resets to 0x3ff in bits 10:1.
// - Identity register returns a fixed value.
// - Primary address matches where its mask bits are 1.
// - Long address mode for both addresses comes from the primary register.
`timescale 1ns/1ns
`include "i2ct_cfg.svh"
module i2ct_status
  import i2ct_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        scl_pin,
  input  wire logic        sda_pin,
  input  wire logic [2:0]  ctl_state,
  input  wire logic [3:0]  ctl_step,
  input  wire logic        addr_valid,
  input  wire logic [10:0] rx_addr,
  input  wire logic [10:0] prim_addr,
  input  wire logic [10:0] prim_mask,
  input  wire logic        long_address_select,
  input  wire logic        word_sent,
  input  wire logic        word_received,
  input  wire logic        word_nacked,
  input  wire logic        send_stall_flag,
  input  wire logic        receive_stall_flag,
  input  wire logic        send_underrun,
  input  wire logic        receive_overrun,
  input  wire logic [4:0]  rx_level,
  input  wire logic [4:0]  tx_level,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             addr_hit,
  output logic             rx_flush,
  output logic             tx_flush,
  output logic             irq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [1:0]     pins_s;
  logic           scl_s;
  logic           sda_s;
  logic           sda_prev_q;
  logic           start_det;
  logic           stop_det;
  logic           busy_q;
  logic           prim_hit;
  logic           sec_hit;
  logic           hit;
  logic           end_evt;
  i2ct_phase_type phase_q;
  i2ct_phase_type phase_d;
  logic           done_q;
  logic           hit_flag_q;
  logic           refused_q;
  logic           first_q;
  logic [31:0]    stat_d;
  logic [31:0]    stat_q;
  logic [10:0]    sent_cnt_q;
  logic [10:0]    recv_cnt_q;
  logic [15:0]    enb_q;
  logic [15:0]    raw_q;
  logic [15:0]    src;
  logic [15:0]    clr;
  logic [4:0]     rxtrg_q;
  logic [4:0]     txtrg_q;
  logic [10:0]    addrb_q;
  logic           second_on_q;
  logic [10:0]    maskb_q;
  logic [1:0]     flush_q;

  function automatic logic is_wr(input logic [7:0] off);
    return reg_wr && (reg_addr == off);
  endfunction

  // --------------------------------------------------------------------------
  // Bus pins and start/stop detection
  // --------------------------------------------------------------------------
  // The link clock is sampled, so the bus must stay well below ref_clk / 4.
  i2ct_sync #(.W(2)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({scl_pin, sda_pin}),
    .sync_out (pins_s)
  );

  assign scl_s     = pins_s[1];
  assign sda_s     = pins_s[0];
  assign start_det = scl_s && sda_prev_q && !sda_s;
  assign stop_det  = scl_s && !sda_prev_q && sda_s;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sda_prev_q <= 1'b1;
      busy_q     <= 1'b0;
    end else begin
      sda_prev_q <= sda_s;
      if (start_det) begin
        busy_q <= 1'b1;
      end else if (stop_det) begin
        busy_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Address matching
  // --------------------------------------------------------------------------
  i2ct_addr_cmp u_cmp_prim (
    .rx_addr             (rx_addr),
    .ref_addr            (prim_addr),
    .mask                (prim_mask),
    .long_address_select (long_address_select),
    .hit                 (prim_hit)
  );

  i2ct_addr_cmp u_cmp_sec (
    .rx_addr             (rx_addr),
    .ref_addr            (addrb_q),
    .mask                (maskb_q),
    .long_address_select (long_address_select),
    .hit                 (sec_hit)
  );

  assign hit      = addr_valid && (prim_hit || (second_on_q && sec_hit));
  assign addr_hit = hit;

  // --------------------------------------------------------------------------
  // Transaction phase
  // --------------------------------------------------------------------------
  assign end_evt = (phase_q == PH_ACTIVE) && (stop_det || start_det);

  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      PH_IDLE: begin
        if (hit) phase_d = PH_ACTIVE;
      end
      PH_ACTIVE: begin
        if (stop_det) phase_d = PH_IDLE;
        else if (start_det) phase_d = PH_HELD;
      end
      PH_HELD: begin
        if (hit) phase_d = PH_ACTIVE;
        else if (stop_det) phase_d = PH_IDLE;
      end
      default: phase_d = PH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // --------------------------------------------------------------------------
  // Sticky transaction flags
  // --------------------------------------------------------------------------
  // Each set is applied after its clear, so a coinciding event is kept.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_q     <= 1'b0;
      hit_flag_q <= 1'b0;
      refused_q  <= 1'b0;
      first_q    <= 1'b0;
    end else begin
      if (hit) done_q <= 1'b0;
      if (end_evt) done_q <= 1'b1;
      if (end_evt) hit_flag_q <= 1'b0;
      if (hit) hit_flag_q <= 1'b1;
      if (hit) refused_q <= 1'b0;
      if (word_nacked) refused_q <= 1'b1;
      if (word_received) first_q <= 1'b0;
      if (hit) first_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Status word
  // --------------------------------------------------------------------------
  always_comb begin
    stat_d                   = 32'h0000_0000;
    stat_d[`I2CT_ST_DONE]    = done_q;
    stat_d[`I2CT_ST_IDLE]    = (phase_q == PH_IDLE);
    stat_d[`I2CT_ST_WAIT]    = (phase_q == PH_HELD);
    stat_d[`I2CT_ST_TXSTALL] = send_stall_flag;
    stat_d[`I2CT_ST_RXSTALL] = receive_stall_flag;
    stat_d[`I2CT_ST_HIT]     = hit_flag_q;
    stat_d[`I2CT_ST_REFUSED] = refused_q;
    stat_d[`I2CT_ST_FIRST]   = first_q;
    stat_d[`I2CT_ST_RX_HAS_DATA] = (rx_level != 5'h00);
    stat_d[`I2CT_ST_RX_AT_CAPACITY]  = (rx_level == `I2CT_FIFO_FULL);
    stat_d[`I2CT_ST_RXTRIG]  = (rx_level >= rxtrg_q);
    stat_d[`I2CT_ST_TX_DRAINED] = (tx_level == 5'h00);
    stat_d[`I2CT_ST_TX_HAS_ROOM] = (tx_level != `I2CT_FIFO_FULL);
    stat_d[`I2CT_ST_TXLOW]   = (tx_level < txtrg_q);
    stat_d[`I2CT_ST_BUSY]    = busy_q;
    stat_d[`I2CT_ST_SDA]     = sda_s;
    stat_d[`I2CT_ST_SCL]     = scl_s;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_q <= `I2CT_STATUS_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // --------------------------------------------------------------------------
  // Word counters
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sent_cnt_q <= 11'h000;
      recv_cnt_q <= 11'h000;
    end else if (hit) begin
      sent_cnt_q <= 11'h000;
      recv_cnt_q <= 11'h000;
    end else begin
      if (word_sent && sent_cnt_q != `I2CT_CNT_MAX) begin
        sent_cnt_q <= sent_cnt_q + 11'h001;
      end
      if (word_received && recv_cnt_q != `I2CT_CNT_MAX) begin
        recv_cnt_q <= recv_cnt_q + 11'h001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt sources
  // --------------------------------------------------------------------------
  // Level sources 15:12 re-arm while their condition holds, so a clear only
  // sticks once the FIFO condition has gone away.
  always_comb begin
    src[7:0] = stat_d[7:0] & ~stat_q[7:0];
    src[8]   = start_det;
    src[9]   = stop_det;
    src[10]  = send_underrun;
    src[11]  = receive_overrun;
    src[12]  = stat_d[`I2CT_ST_TXLOW];
    src[13]  = stat_d[`I2CT_ST_RXTRIG];
    src[14]  = stat_d[`I2CT_ST_TX_DRAINED];
    src[15]  = stat_d[`I2CT_ST_RX_AT_CAPACITY];
    clr      = is_wr(`I2CT_OFF_IRQ_CLR) ? reg_wdata[15:0] : 16'h0000;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      raw_q <= 16'h0000;
    end else begin
      raw_q <= (raw_q & ~clr) | src;
    end
  end

  assign irq = |(raw_q & enb_q);

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enb_q       <= 16'h0000;
      rxtrg_q     <= `I2CT_TRG_RST;
      txtrg_q     <= `I2CT_TRG_RST;
      addrb_q     <= 11'h000;
      second_on_q <= 1'b0;
      maskb_q     <= `I2CT_MASKB_RST;
    end else begin
      if (is_wr(`I2CT_OFF_IRQ_ENB)) enb_q <= reg_wdata[15:0];
      if (is_wr(`I2CT_OFF_RXTRG)) rxtrg_q <= reg_wdata[4:0];
      if (is_wr(`I2CT_OFF_TXTRG)) txtrg_q <= reg_wdata[4:0];
      if (is_wr(`I2CT_OFF_ADDRB)) begin
        addrb_q     <= reg_wdata[10:0];
        second_on_q <= reg_wdata[`I2CT_ADDRB_EN];
      end
      if (is_wr(`I2CT_OFF_MASKB)) maskb_q <= reg_wdata[10:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flush_q <= 2'b00;
    end else begin
      flush_q <= is_wr(`I2CT_OFF_FLUSH) ? reg_wdata[1:0] : 2'b00;
    end
  end

  assign rx_flush = flush_q[0];
  assign tx_flush = flush_q[1];

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      unique case (reg_addr)
        `I2CT_OFF_STATUS:  reg_rdata <= stat_q;
        `I2CT_OFF_STATE:   reg_rdata <= {13'h0000, tx_level, 1'b0, rx_level,
                                         ctl_step, 1'b0, ctl_state};
        `I2CT_OFF_TXCNT:   reg_rdata <= {21'h00_0000, sent_cnt_q};
        `I2CT_OFF_RXCNT:   reg_rdata <= {21'h00_0000, recv_cnt_q};
        `I2CT_OFF_IRQ_ENB: reg_rdata <= {16'h0000, enb_q};
        `I2CT_OFF_IRQ_RAW: reg_rdata <= {16'h0000, raw_q};
        `I2CT_OFF_IRQ_END: reg_rdata <= {16'h0000, raw_q & enb_q};
        `I2CT_OFF_RXTRG:   reg_rdata <= {27'h000_0000, rxtrg_q};
        `I2CT_OFF_TXTRG:   reg_rdata <= {27'h000_0000, txtrg_q};
        `I2CT_OFF_ADDRB:   reg_rdata <= {16'h0000, second_on_q, 4'h0, addrb_q};
        `I2CT_OFF_MASKB:   reg_rdata <= {`I2CT_MASKB_ONES, maskb_q};
        `I2CT_OFF_PERIPHERAL_IDENTITY:   reg_rdata <= `I2CT_PERIPHERAL_IDENTITY;
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence seq_active_end_stop;
    phase_q == PH_ACTIVE && stop_det;
  endsequence

  sequence seq_rstart;
    phase_q == PH_ACTIVE && start_det && !stop_det;
  endsequence

  sequence seq_matched;
    hit;
  endsequence

  AST_DONE_AFTER_STOP: assert property (
    seq_active_end_stop |=> done_q ##1 (stat_q[`I2CT_ST_DONE] && stat_q[`I2CT_ST_IDLE]))
    else $error("done or idle status missing after stop");

  AST_IDLE_TRACKS_PHASE: assert property (
    (phase_q == PH_IDLE) |=> stat_q[`I2CT_ST_IDLE])
    else $error("idle status not shown while idle");

  AST_WAIT_ON_RESTART: assert property (
    seq_rstart |=> (phase_q == PH_HELD) ##1 (stat_q[`I2CT_ST_WAIT] && !stat_q[`I2CT_ST_IDLE]))
    else $error("waiting status missing after repeated start");

  AST_MATCH_FLAGS: assert property (
    seq_matched |=> ##1 (stat_q[`I2CT_ST_HIT] && stat_q[`I2CT_ST_FIRST] && !stat_q[`I2CT_ST_DONE]))
    else $error("match flags wrong after address match");

  AST_COUNTS_CLEAR: assert property (
    seq_matched |=> (sent_cnt_q == 11'h000 && recv_cnt_q == 11'h000))
    else $error("word counters not cleared on match");

  AST_SENT_HOLDS: assert property (
    (sent_cnt_q == `I2CT_CNT_MAX && !hit) |=> sent_cnt_q == `I2CT_CNT_MAX)
    else $error("sent counter left its ceiling");

  AST_RECV_STEP: assert property (
    (word_received && !hit && recv_cnt_q < `I2CT_CNT_MAX) |=>
      recv_cnt_q == $past(recv_cnt_q) + 11'h001)
    else $error("received counter did not step");

  AST_EDGE_LATCH: assert property (
    (!stat_q[`I2CT_ST_REFUSED] && stat_d[`I2CT_ST_REFUSED]) |=> raw_q[`I2CT_ST_REFUSED])
    else $error("rising status edge not latched");

  AST_CLEAR_BIT: assert property (
    (is_wr(`I2CT_OFF_IRQ_CLR) && reg_wdata[9] && !src[9]) |=> !raw_q[9])
    else $error("pending bit survived its clear");

  AST_IRQ_OUT: assert property (
    ((raw_q & enb_q) != 16'h0000) |-> irq)
    else $error("interrupt output low with enabled pending bit");

  AST_ENABLE_GATES: assert property (
    (enb_q == 16'h0000) |-> !irq)
    else $error("interrupt raised with all enables clear");

endmodule // i2ct_status

/* File: design/i2ct_sync.sv */
/*
  Two-stage synchroniser for pin levels.
  Assumes the inputs are asynchronous to ref_clk.
*/
`timescale 1ns/1ns
module i2ct_sync #(
  parameter int W = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // i2ct_sync

/* File: test/i2ct_bus_model.sv */
/*
  Bus controller model that makes start and stop conditions on the pins.
  Assumes pulled-up lines; the link clock stands still between frames.
*/
`timescale 1ns/1ns
module i2ct_bus_model (
  output logic scl,
  output logic sda
);
  // Half of the 80 ns link period.
  localparam int HP = 40;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic send_start();
    sda = 1'b1;
    #HP scl = 1'b1;
    #HP sda = 1'b0;
    #HP scl = 1'b0;
  endtask
  // The clock is lowered first, so that pulling data low never reads as a start.
  task automatic send_stop();
    scl = 1'b0;
    #HP sda = 1'b0;
    #HP scl = 1'b1;
    #HP sda = 1'b1;
  endtask
endmodule // i2ct_bus_model

/* File: test/i2ct_status_tb_top.sv */
/*
  Self-checking bench of the target status block.
  Assumes the bus model on the pins and a 125 MHz ref_clk.
*/
`timescale 1ns/1ns
`include "i2ct_cfg.svh"
module i2ct_status_tb_top;
  logic        ref_clk, rst, addr_valid, long_address_select, word_sent, word_received;
  logic        word_nacked, send_stall_flag, receive_stall_flag, send_underrun;
  logic        receive_overrun, reg_wr, reg_rd, addr_hit, rx_flush, tx_flush, irq, lg, se;
  logic [2:0]  ctl_state;
  logic [3:0]  ctl_step;
  logic [10:0] rx_addr, prim_addr, prim_mask, pa, pm, sa, sm, ra;
  logic [4:0]  rx_level, tx_level, rt, tt;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic        scl, sda;
  int          num_errors, samples_checked, seed;

  i2ct_bus_model u_bus (.scl(scl), .sda(sda));
  i2ct_status u_dut (.ref_clk(ref_clk), .rst(rst), .scl_pin(scl), .sda_pin(sda),
    .ctl_state(ctl_state), .ctl_step(ctl_step), .addr_valid(addr_valid), .rx_addr(rx_addr),
    .prim_addr(prim_addr), .prim_mask(prim_mask), .long_address_select(long_address_select),
    .word_sent(word_sent), .word_received(word_received), .word_nacked(word_nacked),
    .send_stall_flag(send_stall_flag), .receive_stall_flag(receive_stall_flag),
    .send_underrun(send_underrun), .receive_overrun(receive_overrun), .rx_level(rx_level),
    .tx_level(tx_level), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_hit(addr_hit), .rx_flush(rx_flush),
    .tx_flush(tx_flush), .irq(irq));

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] st_f(input logic [4:0] r, t, rtg, ttg);
    st_f = 32'hc000_0002;
    st_f[8] = r != 5'h00;
    st_f[9] = r == 5'h10;
    st_f[11] = r >= rtg;
    st_f[12] = t == 5'h00;
    st_f[13] = t != 5'h10;
    st_f[15] = t < ttg;
  endfunction
  function automatic logic hit_f(input logic [10:0] a, r, m, input logic l);
    logic [10:0] mm;
    mm = l ? m : {3'b000, m[7:0]};
    hit_f = ((a ^ r) & mm) == 11'h000;
  endfunction
  task automatic wrap_up();
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tk(1);
    reg_wr <= 1'b0;
    tk(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tk(1);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    tk(1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    rd(a, v);
    chk($sformatf("reg_%h", a), e, v & m);
  endtask
  task automatic hit(input logic [10:0] a, input logic e);
    rx_addr <= a;
    addr_valid <= 1'b1;
    #1 chk("addr_hit", {31'h0, e}, {31'h0, addr_hit});
    tk(1);
    addr_valid <= 1'b0;
    tk(1);
  endtask
  task automatic words(input int n, input logic r);
    repeat (n) begin
      word_sent <= !r;
      word_received <= r;
      tk(1);
      {word_sent, word_received} <= 2'b00;
      tk(1);
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    tk(100000);
    num_errors++;
    wrap_up();
  end

  initial begin
    {rst, seed, num_errors, samples_checked} = {1'b1, 32'd58718, 64'd0};
    {addr_valid, long_address_select, word_sent, word_received, word_nacked} = 5'h00;
    {send_stall_flag, receive_stall_flag, send_underrun, receive_overrun} = 4'h0;
    {reg_wr, reg_rd, ctl_state, ctl_step, rx_addr, prim_addr, prim_mask} = 42'h0;
    {rx_level, tx_level, reg_addr, reg_wdata} = 50'h0;
    tk(20);
    rst <= 1'b0;
    tk(2);
    rc(`I2CT_OFF_RXTRG, 32'hffff_ffff, 32'h0000_0008);
    rc(`I2CT_OFF_TXTRG, 32'hffff_ffff, 32'h0000_0008);
    rc(`I2CT_OFF_MASKB, 32'hffff_ffff, 32'hffff_fffe);
    rc(`I2CT_OFF_IRQ_ENB, 32'hffff_ffff, 32'h0000_0000);
    rc(`I2CT_OFF_PERIPHERAL_IDENTITY, 32'hffff_ffff, `I2CT_PERIPHERAL_IDENTITY);
    rc(8'h3c, 32'hffff_ffff, 32'h0000_0000);
    for (int i = 0; i < 12; i++) begin
      rt = 5'($random(seed));
      tt = 5'($random(seed));
      wr(`I2CT_OFF_RXTRG, {27'h0, rt});
      wr(`I2CT_OFF_TXTRG, {27'h0, tt});
      v = $random(seed);
      rx_level <= (i < 2) ? {i[0], 4'h0} : 5'($unsigned(v) % 17);
      tx_level <= (i < 2) ? {~i[0], 4'h0} : 5'($unsigned(v >> 8) % 17);
      {ctl_state, ctl_step} <= v[30:24];
      tk(4);
      rc(`I2CT_OFF_STATUS, 32'hffff_ffe7, st_f(rx_level, tx_level, rt, tt));
      rc(`I2CT_OFF_STATE, 32'hffff_ffff,
         {13'h0, tx_level, 1'b0, rx_level, ctl_step, 1'b0, ctl_state});
      send_stall_flag <= v[0];
      receive_stall_flag <= v[1];
      tk(4);
      rc(`I2CT_OFF_STATUS, 32'h0000_0018, {27'h0, v[1:0], 3'h0});
    end
    for (int i = 0; i < 12; i++) begin
      {pa, sa, ra} = {11'($random(seed)), 11'($random(seed)), 11'($random(seed))};
      {pm, sm, lg, se} = {10'($random(seed)), 1'b0, 10'($random(seed)), 1'b0, 2'($random(seed))};
      ra = (i % 3 == 0) ? pa : (i % 3 == 1) ? sa : ra;
      {prim_addr, prim_mask, long_address_select} <= {pa, pm, lg};
      wr(`I2CT_OFF_ADDRB, {16'h0, se, 4'h0, sa});
      wr(`I2CT_OFF_MASKB, {21'h0, sm});
      hit(ra, hit_f(ra, pa, pm, lg) | (se & hit_f(ra, sa, sm, lg)));
    end
    u_bus.send_stop();
    tk(1);
    {prim_addr, prim_mask, long_address_select} <= {11'h0a4, 11'h7fe, 1'b0};
    wr(`I2CT_OFF_ADDRB, 32'h0000_0000);
    u_bus.send_start();
    tk(8);
    hit(11'h0a4, 1'b1);
    words(3, 1'b0);
    words(2, 1'b1);
    word_nacked <= 1'b1;
    tk(1);
    word_nacked <= 1'b0;
    tk(3);
    rc(`I2CT_OFF_TXCNT, 32'hffff_ffff, 32'h0000_0003);
    rc(`I2CT_OFF_RXCNT, 32'hffff_ffff, 32'h0000_0002);
    rc(`I2CT_OFF_STATUS, 32'h0000_00e7, 32'h0000_0060);
    u_bus.send_start();
    tk(8);
    rc(`I2CT_OFF_STATUS, 32'h0000_0007, 32'h0000_0005);
    hit(11'h0a4, 1'b1);
    tk(2);
    rc(`I2CT_OFF_TXCNT, 32'hffff_ffff, 32'h0000_0000);
    rc(`I2CT_OFF_STATUS, 32'h0000_0087, 32'h0000_0080);
    wr(`I2CT_OFF_IRQ_ENB, 32'h0000_0200);
    wr(`I2CT_OFF_IRQ_CLR, 32'hffff_ffff);
    #1 chk("irq", 32'h0, {31'h0, irq});
    u_bus.send_stop();
    tk(8);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rc(`I2CT_OFF_IRQ_RAW, 32'h0000_0301, 32'h0000_0201);
    rc(`I2CT_OFF_STATUS, 32'h0000_0007, 32'h0000_0003);
    wr(`I2CT_OFF_IRQ_CLR, 32'h0000_0001);
    rc(`I2CT_OFF_IRQ_RAW, 32'h0000_0201, 32'h0000_0200);
    wr(`I2CT_OFF_IRQ_CLR, 32'h0000_0200);
    #1 chk("irq", 32'h0, {31'h0, irq});
    send_underrun <= 1'b1;
    tk(1);
    send_underrun <= 1'b0;
    wr(`I2CT_OFF_IRQ_ENB, 32'h0000_0400);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rc(`I2CT_OFF_IRQ_END, 32'hffff_ffff, 32'h0000_0400);
    for (int d = 1; d < 4; d++) begin
      {reg_addr, reg_wdata, reg_wr} <= {`I2CT_OFF_FLUSH, d, 1'b1};
      tk(1);
      reg_wr <= 1'b0;
      #1 chk("flush", d, {30'h0, tx_flush, rx_flush});
      tk(1);
      #1 chk("flush", 32'h0, {30'h0, tx_flush, rx_flush});
      tk(1);
    end
    hit(11'h0a4, 1'b1);
    words(2050, 1'b0);
    words(2050, 1'b1);
    rc(`I2CT_OFF_TXCNT, 32'hffff_ffff, {21'h0, `I2CT_CNT_MAX});
    rc(`I2CT_OFF_RXCNT, 32'hffff_ffff, {21'h0, `I2CT_CNT_MAX});
    wrap_up();
  end
endmodule // i2ct_status_tb_top
